/* File: dv/fpcs_lane_src.sv */
`timescale 1ns/100ps
`default_nettype none

// Serial medium model: sends one ten-bit frame on all four lanes
module fpcs_lane_src
(
   output var logic o_link_clk,
   output var logic [3:0] o_lanes
);
   // Link clock stands low between frames
   initial
   begin
      o_link_clk = 1'b0;
      o_lanes = 4'h0;
   end

   // Bit k of each lane goes out k-th; lanes inverted once released
   task automatic send(input logic [39:0] w);
      int k;
      #3.3;
      for (k = 0; k < 10; k++)
      begin
         o_lanes = {w[30+k], w[20+k], w[10+k], w[k]};
         #62.5 o_link_clk = 1'b1;
         #62.5 o_link_clk = 1'b0;
      end
      o_lanes = ~o_lanes;
   endtask
endmodule // fpcs_lane_src

`default_nettype wire

/* File: dv/fpcs_rx_pma_test.sv */
`timescale 1ns/100ps
`default_nettype none

module fpcs_rx_pma_test
   import fpcs_pkg::*;
;
   // Ten-bit code-groups, first-sent bit in bit 0
   localparam logic [9:0] KI = 10'h17c; // idle comma
   localparam logic [9:0] KQ = 10'h13c; // sequence marker
   localparam logic [9:0] KT = 10'h05d; // terminate
   localparam logic [9:0] D0 = 10'h0b9; // data zero
   localparam logic [9:0] BAD = 10'h000; // not in any table
   localparam logic [39:0] TXW = 40'h5a_3c91_e7b4;
   localparam logic [39:0] RXW [2] = '{40'h96_c3a5_0f71, 40'hc1_5e3a_8d27};
   localparam int LIMIT = 20000;

   typedef struct packed {
      logic al;
      logic [39:0] col;
      logic [31:0] rxd;
      logic [3:0] rxc;
   } fpcs_row_t;

   // Column sequence walks all mode changes
   localparam fpcs_row_t ROWS [18] = '{
      '{1'b1, {KI, KI, KI, KI}, 32'h0707_0707, 4'hf},
      '{1'b1, {D0, D0, D0, D0}, 32'h0000_0000, 4'h0},
      '{1'b1, {KI, KI, KI, KI}, 32'hbcbc_bcbc, 4'hf},
      '{1'b1, {D0, D0, D0, KT}, 32'h0000_00fd, 4'h1},
      '{1'b1, {KI, KI, KI, KI}, 32'h0707_0707, 4'hf},
      '{1'b1, {KI, BAD, KI, KI}, 32'hbcfe_bcbc, 4'hf},
      '{1'b1, {D0, D0, D0, KT}, 32'h0000_00fd, 4'h1},
      '{1'b1, {D0, D0, D0, KQ}, 32'h0000_009c, 4'h1},
      '{1'b1, {KI, KI, KI, KI}, 32'h0707_0707, 4'hf},
      '{1'b0, {D0, D0, D0, D0}, 32'h0100_009c, 4'h1},
      '{1'b1, {D0, D0, D0, D0}, 32'h0000_0000, 4'h0},
      '{1'b1, {D0, D0, D0, BAD}, 32'h0000_00fe, 4'h1},
      '{1'b1, {D0, D0, D0, KQ}, 32'h0000_009c, 4'h1},
      '{1'b1, {KI, KI, KI, KI}, 32'hbcbc_bcbc, 4'hf},
      '{1'b1, {D0, D0, D0, KT}, 32'h0000_00fd, 4'h1},
      '{1'b1, {D0, D0, D0, KQ}, 32'h0000_009c, 4'h1},
      '{1'b1, {D0, D0, D0, D0}, 32'h0000_0000, 4'h0},
      '{1'b1, {KI, KI, KI, KI}, 32'hbcbc_bcbc, 4'hf}
   };

   logic clk, resetn, align_ok, col_valid, pma_fault, tx_valid, link_clk;
   logic rx_clk, link_ok, tx_ready, tx_bit_stb, rx_word_valid;
   logic [39:0] col, tx_code, rx_word;
   logic [31:0] rxd;
   logic [3:0] rxc, tx_serial, rx_lanes;
   int bad_count, comparisons, cycles, n, tc, i, k;

   fpcs_rx_pma i_fpcs_rx_pma (
      .i_clk(clk), .i_resetn(resetn), .i_align_status(align_ok), .i_align_col(col),
      .i_align_valid(col_valid), .i_pma_fault(pma_fault), .o_rxd(rxd), .o_rxc(rxc),
      .o_rx_clk(rx_clk), .o_link_ok(link_ok), .i_tx_code(tx_code), .i_tx_valid(tx_valid),
      .o_tx_ready(tx_ready), .o_tx_serial(tx_serial), .o_tx_bit_stb(tx_bit_stb),
      .i_link_clk(link_clk), .i_rx_serial(rx_lanes), .o_rx_unaligned(rx_word),
      .o_rx_unaligned_valid(rx_word_valid));

   fpcs_lane_src i_fpcs_lane_src (.o_link_clk(link_clk), .o_lanes(rx_lanes));

   // Clock generation
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Compare and count
   task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One column in, result sampled just after the edge that takes it
   task automatic send_col(input logic al, input logic [39:0] c);
      @(posedge clk);
      align_ok <= al;
      col <= c;
      col_valid <= 1'b1;
      @(posedge clk);
      col_valid <= 1'b0;
      #1;
   endtask

   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         bad_count++;
         wrap_up();
      end
   end

   initial
   begin
      resetn = 1'b0;
      align_ok = 1'b1;
      col_valid = 1'b0;
      col = '0;
      pma_fault = 1'b0;
      tx_valid = 1'b0;
      tx_code = '0;
      bad_count = 0;
      comparisons = 0;
      cycles = 0;
      repeat (20) @(posedge clk);
      #1;
      check("rst_rxd", 40'(rxd), 40'(RXD_RST));
      check("rst_rxc", 40'(rxc), 40'(RXC_RST));
      check("rst_flags", 40'({link_ok, rx_clk, tx_bit_stb, rx_word_valid, tx_ready, tx_serial}),
         40'h00_0000_0000);
      check("rst_rx_word", rx_word, 40'h00_0000_0000);
      @(posedge clk);
      resetn <= 1'b1;
      tx_code <= TXW;
      tx_valid <= 1'b1;
      // Transmit word: bit timing and lane order
      n = 0;
      do begin @(posedge clk); #1; n++; end while (tx_ready !== 1'b1 && n < 300);
      tc = 0;
      for (k = 0; k < 10; k++)
      begin
         do begin @(posedge clk); #1; tc++; end while (tx_bit_stb !== 1'b1 && tc < 300);
         check("tx_bit_time", 40'(tc), 40'(1 + TX_BIT_CYC * k));
         check("tx_serial", 40'(tx_serial), 40'({TXW[30+k], TXW[20+k], TXW[10+k], TXW[k]}));
      end
      do begin @(posedge clk); #1; tc++; end while (tx_ready !== 1'b1 && tc < 400);
      check("tx_word_time", 40'(tc), 40'(10 * TX_BIT_CYC));
      // Column decode table
      for (i = 0; i < 18; i++)
      begin
         send_col(ROWS[i].al, ROWS[i].col);
         check("rx_clk", 40'(rx_clk), 40'h1);
         check("rxd", 40'(rxd), 40'(ROWS[i].rxd));
         check("rxc", 40'(rxc), 40'(ROWS[i].rxc));
      end
      // Link status for every alignment and fault combination
      for (i = 0; i < 4; i++)
      begin
         @(posedge clk);
         align_ok <= i[0];
         pma_fault <= i[1];
         @(posedge clk);
         @(posedge clk);
         #1;
         check("link_ok", 40'(link_ok), 40'(i[0] & ~i[1]));
      end
      // Two back-to-back serial words
      for (i = 0; i < 2; i++)
      begin
         n = 0;
         fork
            i_fpcs_lane_src.send(RXW[i]);
            do begin @(posedge clk); #1; n++; end while (rx_word_valid !== 1'b1 && n < 400);
         join
         check("rx_word", rx_word, RXW[i]);
         check("rx_found", 40'(n < 400), 40'h1);
      end
      // Reset in mid-run: outputs back to rest, word timer restarts
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      #1;
      check("mid_rxd", 40'(rxd), 40'(RXD_RST));
      check("mid_flags", 40'({rxc, link_ok, rx_clk, tx_ready, tx_bit_stb, tx_serial, rx_word_valid}),
         40'({RXC_RST, 9'h000}));
      check("mid_rx_word", rx_word, 40'h00_0000_0000);
      @(posedge clk);
      resetn <= 1'b1;
      n = 0;
      do begin @(posedge clk); #1; n++; end while (tx_ready !== 1'b1 && n < 300);
      check("tx_restart", 40'(n), 40'(TX_BIT_CYC - 1));
      wrap_up();
   end
endmodule // fpcs_rx_pma_test

`default_nettype wire

/* File: src/fpcs_pkg.sv */
package fpcs_pkg;
   // Clock and link timing
   localparam int CLK_NS = 10;
   localparam int LINK_BIT_NS = 125;
   localparam int TX_BIT_CYC = (LINK_BIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int TX_DIV_W = 4;
   localparam logic [TX_DIV_W-1:0] TX_DIV_LAST = TX_DIV_W'(TX_BIT_CYC - 1);

   // Lane geometry
   localparam int LANES = 4;
   localparam int CG_W = 10;
   localparam int COL_W = LANES * CG_W;
   localparam logic [3:0] BIT_LAST = 4'h9;
   localparam logic [3:0] BIT_FIRST = 4'h0;

   // Character codes
   localparam logic [7:0] XG_IDLE = 8'h07;
   localparam logic [7:0] XG_ERR = 8'hfe;
   localparam logic [7:0] XG_TERM = 8'hfd;
   localparam logic [7:0] XG_SEQ = 8'h9c;
   localparam logic [7:0] CG_SYNC = 8'hbc;
   localparam logic [7:0] CG_SKIP = 8'h1c;
   localparam logic [7:0] CG_ALIGN = 8'h7c;
   localparam logic [4:0] K_VAL = 5'h1c;

   // Local fault column and reset values
   localparam logic [31:0] LF_RXD = 32'h0100_009c;
   localparam logic [3:0] LF_RXC = 4'h1;
   localparam logic [31:0] RXD_RST = 32'h0707_0707;
   localparam logic [3:0] RXC_RST = 4'hf;

   // Receive modes
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DATA = 3'b010,
      ST_FAULT = 3'b100
   } fpcs_mode_t;
endpackage

/* File: src/fpcs_rx_pma.sv */
// Notes on behaviour
// - Decode every aligned column; drive rxd/rxc synchronous to generated receive clock.
// - Data mode in packets; entered on non-idle non-sequence in idle or fault; sequence in idle enters fault mode.
// - In data mode valid code-groups map to their character, legal or not.
// - Invalid code-groups become Error characters; each lane decoded on its own.
// - In idle mode an idle column becomes Idle characters on all lanes.
// - Link ok only when alignment ok and no error blocks the link.
// - Alignment failure is the only receive fault recognised here.
// - Received sequence ordered-sets pass through to the MAC side.
// - Each request serialises four code-groups, ten bits per lane, unchanged.
// - Transmit lowest-numbered bit first, highest last.
// - Vectors taken at the word rate; bit rate is ten times it.
// - Ten bits per lane gathered into one 40-bit unaligned vector.
// - First received bit lands in lowest bit of its lane.
// - No code-group boundary search in the attachment layer.
// - Received vectors come at the word rate, one per ten line bits.
// - Bit clock taken from rising edges of the separate link clock input.
// - Alignment status comes from deskew; fails when any lane loses sync.
`timescale 1ns/100ps
`default_nettype none

module fpcs_rx_pma
   import fpcs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_align_status,
   input wire logic [COL_W-1:0] i_align_col,
   input wire logic i_align_valid,
   input wire logic i_pma_fault,
   output logic [31:0] o_rxd,
   output logic [3:0] o_rxc,
   output logic o_rx_clk,
   output logic o_link_ok,
   input wire logic [COL_W-1:0] i_tx_code,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   output logic [LANES-1:0] o_tx_serial,
   output logic o_tx_bit_stb,
   input wire logic i_link_clk,
   input wire logic [LANES-1:0] i_rx_serial,
   output logic [COL_W-1:0] o_rx_unaligned,
   output logic o_rx_unaligned_valid
);

   // Table decode of one code-group: {valid, control, octet}
   function automatic logic [9:0] fpcs_dec(input logic [9:0] cg);
      logic [5:0] s6;
      logic [3:0] s4;
      logic [4:0] v5;
      logic [2:0] v3;
      logic ok6;
      logic ok4;
      logic k28;
      logic k7;
      s6 = {cg[0], cg[1], cg[2], cg[3], cg[4], cg[5]};
      s4 = {cg[6], cg[7], cg[8], cg[9]};
      ok6 = 1'b1;
      v5 = 5'h00;
      k28 = (s6 == 6'b001111) || (s6 == 6'b110000);
      case (s6)
         6'b100111, 6'b011000: v5 = 5'd0;
         6'b011101, 6'b100010: v5 = 5'd1;
         6'b101101, 6'b010010: v5 = 5'd2;
         6'b110001: v5 = 5'd3;
         6'b110101, 6'b001010: v5 = 5'd4;
         6'b101001: v5 = 5'd5;
         6'b011001: v5 = 5'd6;
         6'b111000, 6'b000111: v5 = 5'd7;
         6'b111001, 6'b000110: v5 = 5'd8;
         6'b100101: v5 = 5'd9;
         6'b010101: v5 = 5'd10;
         6'b110100: v5 = 5'd11;
         6'b001101: v5 = 5'd12;
         6'b101100: v5 = 5'd13;
         6'b011100: v5 = 5'd14;
         6'b010111, 6'b101000: v5 = 5'd15;
         6'b011011, 6'b100100: v5 = 5'd16;
         6'b100011: v5 = 5'd17;
         6'b010011: v5 = 5'd18;
         6'b110010: v5 = 5'd19;
         6'b001011: v5 = 5'd20;
         6'b101010: v5 = 5'd21;
         6'b011010: v5 = 5'd22;
         6'b111010, 6'b000101: v5 = 5'd23;
         6'b110011, 6'b001100: v5 = 5'd24;
         6'b100110: v5 = 5'd25;
         6'b010110: v5 = 5'd26;
         6'b110110, 6'b001001: v5 = 5'd27;
         6'b001110: v5 = 5'd28;
         6'b101110, 6'b010001: v5 = 5'd29;
         6'b011110, 6'b100001: v5 = 5'd30;
         6'b101011, 6'b010100: v5 = 5'd31;
         6'b001111, 6'b110000: v5 = K_VAL;
         default: ok6 = 1'b0;
      endcase
      ok4 = 1'b1;
      v3 = 3'h0;
      case (s4)
         4'b1011, 4'b0100: v3 = 3'd0;
         4'b1001: v3 = 3'd1;
         4'b0101: v3 = 3'd2;
         4'b1100, 4'b0011: v3 = 3'd3;
         4'b1101, 4'b0010: v3 = 3'd4;
         4'b1010: v3 = 3'd5;
         4'b0110: v3 = 3'd6;
         4'b1110, 4'b0001, 4'b0111, 4'b1000: v3 = 3'd7;
         default: ok4 = 1'b0;
      endcase
      k7 = ((s4 == 4'b0111) || (s4 == 4'b1000))
         && ((v5 == 5'd23) || (v5 == 5'd27) || (v5 == 5'd29) || (v5 == 5'd30));
      return {ok6 & ok4, k28 | k7, v3, v5};
   endfunction

   // Per-lane decode and classification
   logic [LANES-1:0] lane_ok;
   logic [LANES-1:0] lane_k;
   logic [LANES-1:0] lane_idle;
   logic [LANES-1:0] lane_term;
   logic [31:0] dec_rxd;
   logic [3:0] dec_rxc;
   logic [7:0] lane_oct [LANES];

   genvar gl;
   generate
      for (gl = 0; gl < LANES; gl++)
      begin : g_dec
         wire logic [9:0] dec_w = fpcs_dec(i_align_col[CG_W*gl +: CG_W]);
         assign lane_ok[gl] = dec_w[9];
         assign lane_k[gl] = dec_w[8];
         assign lane_oct[gl] = dec_w[7:0];
         assign lane_idle[gl] = lane_ok[gl] && lane_k[gl]
            && (lane_oct[gl] == CG_SYNC || lane_oct[gl] == CG_SKIP || lane_oct[gl] == CG_ALIGN);
         assign lane_term[gl] = lane_ok[gl] && lane_k[gl] && (lane_oct[gl] == XG_TERM);
         assign dec_rxd[8*gl +: 8] = lane_ok[gl] ? lane_oct[gl] : XG_ERR;
         assign dec_rxc[gl] = lane_ok[gl] ? lane_k[gl] : 1'b1;
      end
   endgenerate

   // Column classification
   wire logic col_idle = &lane_idle;
   wire logic col_term = |lane_term;
   wire logic col_seq = lane_ok[0] && lane_k[0] && (lane_oct[0] == XG_SEQ)
      && (&lane_ok[3:1]) && !(|lane_k[3:1]);

   // Receive mode state
   fpcs_mode_t mode_reg;
   fpcs_mode_t mode_next;

   always_comb
   begin
      mode_next = mode_reg;
      if (!i_align_status)
         mode_next = ST_IDLE;
      else
         unique case (mode_reg)
            ST_IDLE:
               if (col_seq)
                  mode_next = ST_FAULT; // status sets arrive only between packets
               else if (!col_idle)
                  mode_next = ST_DATA;
            ST_DATA:
               if (col_term)
                  mode_next = ST_IDLE;
            ST_FAULT:
               if (col_idle)
                  mode_next = ST_IDLE;
               else if (!col_seq)
                  mode_next = ST_DATA;
         endcase
   end

   // Output column selection
   wire logic idle_out = col_idle && (mode_reg != ST_DATA);
   wire logic [31:0] rxd_next = !i_align_status ? LF_RXD
      : idle_out ? {4{XG_IDLE}} : dec_rxd;
   wire logic [3:0] rxc_next = !i_align_status ? LF_RXC
      : idle_out ? 4'hf : dec_rxc;

   // Column registers and receive clock pulse
   logic [31:0] rxd_reg;
   logic [3:0] rxc_reg;
   logic rx_clk_reg;
   logic link_ok_reg;

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         mode_reg <= ST_IDLE;
         rxd_reg <= RXD_RST;
         rxc_reg <= RXC_RST;
         rx_clk_reg <= 1'b0;
         link_ok_reg <= 1'b0;
      end
      else
      begin
         rx_clk_reg <= i_align_valid;
         link_ok_reg <= i_align_status && !i_pma_fault;
         if (i_align_valid)
         begin
            mode_reg <= mode_next;
            rxd_reg <= rxd_next;
            rxc_reg <= rxc_next;
         end
      end
   end

   assign o_rxd = rxd_reg;
   assign o_rxc = rxc_reg;
   assign o_rx_clk = rx_clk_reg;
   assign o_link_ok = link_ok_reg;

   // Transmit bit-rate divider
   logic [TX_DIV_W-1:0] tx_div_reg;
   logic [3:0] tx_bit_reg;
   logic tx_stb_reg;
   wire logic tx_tick = (tx_div_reg == TX_DIV_LAST);
   wire logic tx_load = tx_tick && (tx_bit_reg == BIT_LAST);

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         tx_div_reg <= '0;
         tx_bit_reg <= BIT_LAST;
         tx_stb_reg <= 1'b0;
      end
      else
      begin
         tx_div_reg <= tx_tick ? '0 : tx_div_reg + 1'b1;
         tx_stb_reg <= tx_tick;
         if (tx_tick)
            tx_bit_reg <= tx_load ? BIT_FIRST : tx_bit_reg + 1'b1;
      end
   end

   assign o_tx_ready = tx_load;
   assign o_tx_bit_stb = tx_stb_reg;

   // Link clock and serial input synchronisers
   logic lclk_s1;
   logic lclk_s2;
   logic lclk_s3;
   logic [LANES-1:0] rx_s1;
   logic [LANES-1:0] rx_s2;
   logic [3:0] rx_bit_reg;
   logic rx_vld_reg;
   wire logic lclk_rise = lclk_s2 && !lclk_s3;
   wire logic rx_last = lclk_rise && (rx_bit_reg == BIT_LAST);

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         lclk_s1 <= 1'b0;
         lclk_s2 <= 1'b0;
         lclk_s3 <= 1'b0;
         rx_s1 <= '0;
         rx_s2 <= '0;
         rx_bit_reg <= BIT_FIRST;
         rx_vld_reg <= 1'b0;
      end
      else
      begin
         lclk_s1 <= i_link_clk;
         lclk_s2 <= lclk_s1;
         lclk_s3 <= lclk_s2;
         rx_s1 <= i_rx_serial;
         rx_s2 <= rx_s1;
         rx_vld_reg <= rx_last;
         if (lclk_rise)
            rx_bit_reg <= rx_last ? BIT_FIRST : rx_bit_reg + 1'b1;
      end
   end

   assign o_rx_unaligned_valid = rx_vld_reg;

   // Per-lane serialiser and deserialiser
   generate
      for (gl = 0; gl < LANES; gl++)
      begin : g_ser
         logic [CG_W-1:0] tx_sh_reg;
         logic tx_out_reg;
         logic [CG_W-1:0] rx_sh_reg;
         logic [CG_W-1:0] rx_word_reg;
         wire logic [CG_W-1:0] tx_word = i_tx_valid ? i_tx_code[CG_W*gl +: CG_W] : '0;
         wire logic [CG_W-1:0] rx_shift = {rx_s2[gl], rx_sh_reg[CG_W-1:1]};

         always_ff @(posedge i_clk or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               tx_sh_reg <= '0;
               tx_out_reg <= 1'b0;
               rx_sh_reg <= '0;
               rx_word_reg <= '0;
            end
            else
            begin
               if (tx_load)
               begin
                  tx_out_reg <= tx_word[0];
                  tx_sh_reg <= {1'b0, tx_word[CG_W-1:1]};
               end
               else if (tx_tick)
               begin
                  tx_out_reg <= tx_sh_reg[0];
                  tx_sh_reg <= {1'b0, tx_sh_reg[CG_W-1:1]};
               end
               if (lclk_rise)
                  rx_sh_reg <= rx_shift;
               if (rx_last)
                  rx_word_reg <= rx_shift;
            end
         end

         assign o_tx_serial[gl] = tx_out_reg;
         assign o_rx_unaligned[CG_W*gl +: CG_W] = rx_word_reg;
      end
   endgenerate

   // Checks on the receive column path, link status and serial transmit/receive paths
   sequence col_fail_s;
      i_align_valid && !i_align_status;
   endsequence
   sequence lf_out_s;
      o_rx_clk && (o_rxd == LF_RXD) && (o_rxc == LF_RXC);
   endsequence

   fault_column_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      col_fail_s |=> lf_out_s)
      else $error("alignment failure not shown as local fault");
   idle_column_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_align_valid && i_align_status && col_idle && mode_reg != ST_DATA
      |=> o_rxc == 4'hf && o_rxd == {4{XG_IDLE}})
      else $error("idle column not mapped to idle");
   error_lane_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_align_valid && i_align_status && mode_reg == ST_DATA && !lane_ok[0]
      |=> o_rxd[7:0] == XG_ERR && o_rxc[0])
      else $error("invalid code-group not mapped to error");
   data_entry_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_align_valid && i_align_status && mode_reg == ST_IDLE && !col_idle && !col_seq
      |=> mode_reg == ST_DATA)
      else $error("data mode not entered");
   link_state_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $past(i_resetn) |-> o_link_ok == ($past(i_align_status) && !$past(i_pma_fault)))
      else $error("link status wrong");
   rx_order_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_rx_unaligned_valid |-> o_rx_unaligned[CG_W-1] == $past(rx_s2[0]))
      else $error("last received bit not in top position");
   rx_spacing_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_rx_unaligned_valid |=> !o_rx_unaligned_valid [*8])
      else $error("received vectors too close");
   tx_first_bit_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_tx_ready && i_tx_valid |=> o_tx_serial[1] == $past(i_tx_code[CG_W]))
      else $error("lowest bit not sent first");
   tx_spacing_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_tx_ready |=> !o_tx_ready [*8])
      else $error("transmit vectors too close");

endmodule // fpcs_rx_pma

`default_nettype wire
